//--- rtl/dma_irq_mode_pkg.sv
// Constants, register layout and carrier types for the DMA-done interrupt mode slice.
package dma_irq_mode_pkg;

  // ==========================================================================
  // Register map (byte addresses inside the slave window)
  localparam logic [11:0] IMC_D_OFF = 12'h034;
  localparam logic [11:0] STATUS_OFF = 12'h040;

  // ==========================================================================
  // Field layout: one byte per source, sources 53..55 in bytes 1..3
  localparam int NSRC = 3;
  localparam int BYTE_BASE = 1;
  localparam int SENSE_LSB = 4;
  localparam int ROUTE_BIT = 3;
  localparam int FIELD_LSB = 0;
  localparam int STAT_BAD_LSB = 8;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [31:0] IMC_D_RESET = 32'h00000000;
  localparam logic [31:0] IMC_D_MASK = 32'h3F3F3F00;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] imc;
    logic [2:0] prev;
    logic [2:0] pend;
    logic [2:0] trig;
    logic [8:0] chan;
    logic [8:0] lvl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  localparam state_s STATE_RESET = '{
    imc: IMC_D_RESET, prev: 3'h0, pend: 3'h0, trig: 3'h0, chan: 9'h000,
    lvl: 9'h000, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};

endpackage : dma_irq_mode_pkg

//--- rtl/dma_done_interrupt_mode_ctl.sv
// Mode control slice for interrupt sources 53..55 with an APB register port.
//
// Notes on behaviour
// - Sense 10 falling, 11 rising; 00/01 invalid.
// - Route bit set sends request to DMA.
// - Route clear: field is level, 000 disables.
// - Route set: field picks DMA channel 0-7.
`timescale 1ns/100ps

module dma_done_interrupt_mode_ctl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources 53, 54, 55 in bits 0, 1, 2
  input wire logic [2:0] src_irq,
  // Requests towards the processor core
  output logic [2:0] irq_pend,
  output logic [8:0] irq_level,
  // Triggers towards the DMA controller
  output logic [2:0] dma_trig,
  output logic [8:0] dma_chan
);

  // ==========================================================================
  // State and decode
  dma_irq_mode_pkg::state_s st_reg;
  dma_irq_mode_pkg::state_s st_next;
  dma_irq_mode_pkg::apb_req_s req;

  logic [5:0] cfg [dma_irq_mode_pkg::NSRC];
  logic [2:0] edge_hit;
  logic [2:0] set_pend;
  logic [2:0] set_trig;
  logic [2:0] clr_pend;
  logic hit_imc;
  logic hit_stat;
  logic access;
  logic wr_fire;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                 pwdata: pwdata, pstrb: pstrb};

  genvar g;
  generate
    for (g = 0; g < dma_irq_mode_pkg::NSRC; g++) begin : g_cfg
      assign cfg[g] = st_reg.imc[8 * (g + dma_irq_mode_pkg::BYTE_BASE) +: 6];
    end
  endgenerate

  assign hit_imc = (req.paddr == dma_irq_mode_pkg::IMC_D_OFF);
  assign hit_stat = (req.paddr == dma_irq_mode_pkg::STATUS_OFF);
  // The slave always inserts one wait state; pready is a flop.
  assign access = req.psel && req.penable;
  assign wr_fire = access && st_reg.pready && req.pwrite;

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    edge_hit = 3'h0;
    set_pend = 3'h0;
    set_trig = 3'h0;
    clr_pend = 3'h0;

    // Source edge detection and steering.
    for (int i = 0; i < dma_irq_mode_pkg::NSRC; i++) begin
      case (cfg[i][dma_irq_mode_pkg::SENSE_LSB +: 2])
        dma_irq_mode_pkg::SENSE_FALL: begin
          edge_hit[i] = st_reg.prev[i] && !src_irq[i];
        end
        dma_irq_mode_pkg::SENSE_RISE: begin
          edge_hit[i] = !st_reg.prev[i] && src_irq[i];
        end
        default: begin
          // Invalid codes detect nothing rather than guessing an edge.
          edge_hit[i] = 1'b0;
        end
      endcase
      if (cfg[i][dma_irq_mode_pkg::ROUTE_BIT]) begin
        set_trig[i] = edge_hit[i];
      end else begin
        set_pend[i] = edge_hit[i] &&
          (cfg[i][dma_irq_mode_pkg::FIELD_LSB +: 3] != dma_irq_mode_pkg::LEVEL_OFF);
      end
      if (set_trig[i]) begin
        st_next.chan[3 * i +: 3] = cfg[i][dma_irq_mode_pkg::FIELD_LSB +: 3];
      end
      if (set_pend[i]) begin
        st_next.lvl[3 * i +: 3] = cfg[i][dma_irq_mode_pkg::FIELD_LSB +: 3];
      end
    end
    st_next.prev = src_irq;
    st_next.trig = set_trig;

    // APB access phase: answer one cycle after penable rises.
    st_next.pready = access && !st_reg.pready;
    if (access && !st_reg.pready) begin
      st_next.pslverr = !(hit_imc || hit_stat);
      st_next.prdata = 32'h00000000;
      if (!req.pwrite && hit_imc) begin
        st_next.prdata = st_reg.imc;
      end else if (!req.pwrite && hit_stat) begin
        st_next.prdata[2:0] = st_reg.pend;
        for (int i = 0; i < dma_irq_mode_pkg::NSRC; i++) begin
          st_next.prdata[dma_irq_mode_pkg::STAT_BAD_LSB + i] =
            !cfg[i][dma_irq_mode_pkg::SENSE_LSB + 1];
        end
      end
    end

    if (wr_fire && hit_imc) begin
      for (int b = 0; b < 4; b++) begin
        if (req.pstrb[b]) begin
          st_next.imc[8 * b +: 8] = req.pwdata[8 * b +: 8];
        end
      end
      // Reserved bits and the foreign low byte never hold a one.
      st_next.imc = st_next.imc & dma_irq_mode_pkg::IMC_D_MASK;
    end
    if (wr_fire && hit_stat && req.pstrb[0]) begin
      clr_pend = req.pwdata[2:0];
    end

    // A new edge in the clearing cycle stays pending.
    st_next.pend = (st_reg.pend & ~clr_pend) | set_pend;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= dma_irq_mode_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq_pend = st_reg.pend;
  assign irq_level = st_reg.lvl;
  assign dma_trig = st_reg.trig;
  assign dma_chan = st_reg.chan;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_fall(int k);
    st_reg.prev[k] && !src_irq[k];
  endsequence

  sequence s_rise(int k);
    !st_reg.prev[k] && src_irq[k];
  endsequence

  generate
    for (g = 0; g < dma_irq_mode_pkg::NSRC; g++) begin : g_chk
      a_fall_to_pend: assert property (
        (cfg[g][5:4] == dma_irq_mode_pkg::SENSE_FALL && !cfg[g][3] &&
         cfg[g][2:0] != 3'h0) ##0 s_fall(g) |=> irq_pend[g] && !dma_trig[g])
        else $error("Falling edge did not raise the request.");

      a_rise_to_dma: assert property (
        (cfg[g][5:4] == dma_irq_mode_pkg::SENSE_RISE && cfg[g][3]) ##0 s_rise(g)
        |=> dma_trig[g] && dma_chan[3 * g +: 3] == $past(cfg[g][2:0]) ##1 !dma_trig[g])
        else $error("Rising edge did not trigger the chosen channel.");

      a_bad_sense_quiet: assert property (
        !cfg[g][5] |=> !dma_trig[g] && !$rose(irq_pend[g]))
        else $error("Invalid sense code produced an event.");

      a_routed_no_irq: assert property (
        cfg[g][3] |=> !$rose(irq_pend[g]))
        else $error("Routed source raised a core request.");

      a_level_off: assert property (
        (!cfg[g][3] && cfg[g][2:0] == 3'h0) |=> !$rose(irq_pend[g]) && !dma_trig[g])
        else $error("Disabled source raised a request.");

      a_level_shown: assert property (
        $rose(irq_pend[g]) |-> irq_level[3 * g +: 3] == $past(cfg[g][2:0]) &&
        irq_level[3 * g +: 3] != 3'h0)
        else $error("Request level differs from the field.");
    end
  endgenerate

  a_reserved_zero: assert property (
    (st_reg.imc & ~dma_irq_mode_pkg::IMC_D_MASK) == 32'h00000000)
    else $error("Reserved mode bits are set.");

  a_write_taken: assert property (
    (wr_fire && hit_imc && pstrb == 4'hF)
    |=> st_reg.imc == ($past(pwdata) & dma_irq_mode_pkg::IMC_D_MASK))
    else $error("Full write did not land in the mode register.");

  // ==========================================================================
  // Register port checks

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  // The answer always takes one wait state, so ready is low on the first access cycle.
  sequence s_answer;
    !pready ##1 pready;
  endsequence

  a_one_wait: assert property (
    s_setup ##1 s_access |-> s_answer)
    else $error("Slave did not answer after one wait state.");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  a_ready_in_access: assert property (
    pready |-> $past(psel && penable))
    else $error("Ready rose outside an access phase.");

  a_idle_no_ready: assert property (
    !psel |-> !pready)
    else $error("Ready was shown to an idle bus.");

  a_err_unmapped: assert property (
    (pready && !hit_imc && !hit_stat) |-> pslverr && prdata == 32'h00000000)
    else $error("Unmapped access was not refused.");

  a_err_mapped: assert property (
    (pready && (hit_imc || hit_stat)) |-> !pslverr)
    else $error("Mapped access reported an error.");

  a_write_reads_zero: assert property (
    (pready && pwrite) |-> prdata == 32'h00000000)
    else $error("Write answer carried read data.");

  a_read_mode: assert property (
    (s_access ##0 (!pwrite && hit_imc && !pready)) |=> prdata == $past(st_reg.imc))
    else $error("Mode register read returned stale data.");

  a_foreign_write: assert property (
    !(wr_fire && hit_imc) |=> $stable(st_reg.imc))
    else $error("Mode register changed without a write.");

  // Per-source status, clear and hold checks.
  // A clear that meets a new edge must not lose that edge.
  generate
    for (g = 0; g < dma_irq_mode_pkg::NSRC; g++) begin : g_more
      a_pend_sticky: assert property (
        (irq_pend[g] && !(wr_fire && hit_stat && pstrb[0] && pwdata[g])) |=> irq_pend[g])
        else $error("Pending request vanished without a clear.");

      a_pend_clear: assert property (
        (wr_fire && hit_stat && pstrb[0] && pwdata[g] && !set_pend[g]) |=> !irq_pend[g])
        else $error("Status clear did not drop the request.");

      a_set_wins: assert property (
        (clr_pend[g] && set_pend[g]) |=> irq_pend[g])
        else $error("Clear beat a new edge in the same cycle.");

      a_trig_pulse: assert property (
        dma_trig[g] |=> !dma_trig[g])
        else $error("Trigger stood for more than one cycle.");

      a_trig_routed: assert property (
        dma_trig[g] |-> $past(cfg[g][3]))
        else $error("Trigger came from an unrouted source.");

      a_chan_held: assert property (
        !set_trig[g] |=> $stable(dma_chan[3 * g +: 3]))
        else $error("Channel changed without a trigger.");

      a_level_held: assert property (
        !set_pend[g] |=> $stable(irq_level[3 * g +: 3]))
        else $error("Level changed without a new request.");

      a_status_read: assert property (
        (s_access ##0 (!pwrite && hit_stat && !pready)) |=>
        prdata[g] == $past(irq_pend[g]) &&
        prdata[dma_irq_mode_pkg::STAT_BAD_LSB + g] == !$past(cfg[g][5]))
        else $error("Status read differs from the source state.");
    end
  endgenerate

endmodule : dma_done_interrupt_mode_ctl

//--- tb/irq_source_model.sv
// Far-side model of the three interrupt source lines, toggled on command.
`timescale 1ns/100ps

module irq_source_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Toggle request and source lines
  input wire logic [2:0] toggle,
  output logic [2:0] src_irq
);
  // The lines are synchronous levels, so they only move right after a rising edge.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_irq <= 3'h0;
    end else begin
      src_irq <= src_irq ^ toggle;
    end
  end
endmodule : irq_source_model

//--- tb/test_dma_done_interrupt_mode_ctl.sv
// Self-checking bench for the DMA-done interrupt mode slice.
`timescale 1ns/100ps

module test_dma_done_interrupt_mode_ctl;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] toggle = 3'h0;
  logic [31:0] prdata, rd, cfg;
  logic pready, pslverr, err;
  logic [2:0] src_irq, irq_pend, dma_trig, e_pend, e_trig;
  logic [8:0] irq_level, dma_chan;
  logic [8:0] e_lvl = 9'h000, e_chan = 9'h000;
  int n_mismatch = 0, total_checks = 0;

  always #4 core_clk = ~core_clk;

  dma_done_interrupt_mode_ctl u_dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .src_irq, .irq_pend, .irq_level, .dma_trig,
    .dma_chan);
  irq_source_model u_src (.core_clk, .rst_b, .toggle, .src_irq);

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // The slave decides the wait; the master polls pready with no bound of its own.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Bit 1 asks for a DMA trigger, bit 0 for a pending request to the core.
  function automatic logic [1:0] outcome(input logic [7:0] b, input logic rise);
    if (b[5] !== 1'b1 || b[4] !== rise) return 2'h0;
    if (b[3]) return 2'h2;
    return {1'b0, b[2:0] != 3'h0};
  endfunction : outcome

  // ==========================================================================
  // Main sequence
  initial begin
    int s;
    logic [1:0] o;
    s = $urandom(32'h117B684A);
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, dma_irq_mode_pkg::IMC_D_OFF, 32'h0);
    check(rd, dma_irq_mode_pkg::IMC_D_RESET);
    apb(1'b1, dma_irq_mode_pkg::IMC_D_OFF, 32'hFFFFFFFF);
    apb(1'b0, dma_irq_mode_pkg::IMC_D_OFF, 32'h0);
    check(rd, dma_irq_mode_pkg::IMC_D_MASK);
    pstrb <= 4'h4;
    apb(1'b1, dma_irq_mode_pkg::IMC_D_OFF, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, dma_irq_mode_pkg::IMC_D_OFF, 32'h0);
    check(rd, dma_irq_mode_pkg::IMC_D_MASK & 32'hFF00FFFF);
    apb(1'b0, 12'h038, 32'h0);
    check({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 40; i++) begin
      s = $urandom % 3;
      cfg = $urandom & dma_irq_mode_pkg::IMC_D_MASK;
      cfg[21:20] = dma_irq_mode_pkg::SENSE_FALL;
      if (i < 2) cfg[8*s+8 +: 4] = {i[0], i[0], i[0], i[0]};
      apb(1'b1, dma_irq_mode_pkg::IMC_D_OFF, cfg);
      o = outcome(cfg[8*s+8 +: 8], ~src_irq[s]);
      e_trig = {2'h0, o[1]} << s;
      e_pend = {2'h0, o[0]} << s;
      if (o[1]) e_chan[3*s +: 3] = cfg[8*s+8 +: 3];
      if (o[0]) e_lvl[3*s +: 3] = cfg[8*s+8 +: 3];
      toggle <= 3'h1 << s;
      @(posedge core_clk);
      toggle <= 3'h0;
      @(posedge core_clk);
      #1;
      check({dma_trig, irq_pend, irq_level, dma_chan}, {e_trig, e_pend, e_lvl, e_chan});
      apb(1'b0, dma_irq_mode_pkg::STATUS_OFF, 32'h0);
      check(rd, {21'h0, ~cfg[29], ~cfg[21], ~cfg[13], 5'h0, e_pend});
      apb(1'b1, dma_irq_mode_pkg::STATUS_OFF, 32'h7);
      #1;
      check({dma_trig, irq_pend}, 32'h0);
    end
    print_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule : test_dma_done_interrupt_mode_ctl
